/* pwm_pkg.sv */
// package: register map, field positions, reset values and clock choices of the pulse width timer
package pwm_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_SEL = 8'h35;
    localparam logic [ADDR_W-1:0] OFS_HIGH_RESULT = 8'h36;
    localparam logic [ADDR_W-1:0] OFS_LOW_RESULT = 8'h37;
    // control/status field positions
    localparam int unsigned BIT_FILT_LEVEL = 6;
    localparam int unsigned BIT_OVF_IRQ_EN = 5;
    localparam int unsigned BIT_HIGH_OVF = 4;
    localparam int unsigned BIT_LOW_OVF = 3;
    localparam int unsigned BIT_EDGE_HI = 2;
    localparam int unsigned BIT_EDGE_LO = 1;
    localparam int unsigned BIT_EDGE_FLAG = 0;
    // clock select field positions
    localparam int unsigned BIT_CNT_SEL_HI = 3;
    localparam int unsigned BIT_CNT_SEL_LO = 2;
    localparam int unsigned BIT_FLT_SEL_HI = 1;
    localparam int unsigned BIT_FLT_SEL_LO = 0;
    // edge select codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // reset values and counter limit
    localparam logic [1:0] RST_SEL = 2'h0;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    // filter integrator
    localparam logic [2:0] FILT_LEVEL_MIN = 3'h0;
    localparam logic [2:0] FILT_LEVEL_MAX = 3'h6;
    // prescaler: count periods 2,4,8,16 and filter periods 1,2,4,8 instruction cycles
    localparam int unsigned PRESC_W = 4;
    localparam int unsigned CNT_SHIFT_BASE = 1;
    localparam int unsigned FLT_SHIFT_BASE = 0;
    typedef logic [7:0] pwm_byte_t;
endpackage

/* pwm_prescaler.sv */
// prescaler: one-cycle enables with periods of 2^(base+sel) instruction cycles
`timescale 1ns/1ps
module pwm_prescaler import pwm_pkg::*; #(
    parameter int unsigned WIDTH = PRESC_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic inst_en_i,
    input wire logic [1:0] cnt_sel_i,
    input wire logic [1:0] flt_sel_i,
    output logic cnt_tick_o,
    output logic flt_tick_o
);
    typedef struct packed {
        logic [WIDTH-1:0] div;
    } pwm_presc_state_t;

    pwm_presc_state_t s_q;
    pwm_presc_state_t s_d;

    // refused at elaboration: the 16-cycle count period needs four divider bits
    if (WIDTH < 4) begin : g_width_check
        $error("prescaler too narrow for 16-cycle period");
    end

    // enable fires when all bits below the chosen period are ones
    function automatic logic tick_at(input logic [WIDTH-1:0] div, input int unsigned n);
        logic [WIDTH-1:0] mask;
        mask = WIDTH'((1 << n) - 1);
        return (div & mask) == mask;
    endfunction

    always_comb begin
        s_d = s_q;
        if (inst_en_i) begin
            s_d.div = s_q.div + WIDTH'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cnt_tick_o = inst_en_i && tick_at(s_q.div, CNT_SHIFT_BASE + 32'(cnt_sel_i)); // [R15] [R21] [R22]
    assign flt_tick_o = inst_en_i && tick_at(s_q.div, FLT_SHIFT_BASE + 32'(flt_sel_i)); // [R16] [R21] [R22]
endmodule // pwm_prescaler

/* pwm_filter.sv */
// digital low-pass filter: integrator over levels 0..6 with hysteresis output
`timescale 1ns/1ps
module pwm_filter import pwm_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sample_en_i,
    input wire logic pulse_i,
    output logic level_o
);
    typedef struct packed {
        logic [2:0] acc;
        logic out;
    } pwm_filt_state_t;

    pwm_filt_state_t s_q;
    pwm_filt_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (sample_en_i) begin
            if (pulse_i && s_q.acc != FILT_LEVEL_MAX) begin
                s_d.acc = s_q.acc + 3'h1; // [R20]
            end else if (!pulse_i && s_q.acc != FILT_LEVEL_MIN) begin
                s_d.acc = s_q.acc - 3'h1; // [R20]
            end
        end
        // output changes only at the end levels, held in between
        if (s_d.acc == FILT_LEVEL_MAX) begin
            s_d.out = 1'b1; // [R20]
        end else if (s_d.acc == FILT_LEVEL_MIN) begin
            s_d.out = 1'b0; // [R20]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.out;
endmodule // pwm_filter

/* pwm_timer.sv */
// pulse width measurement timer: registers, edge detector, counter and interrupt request
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
// Functional notes
// R1 - bit 6 reads filtered level, read only
// R2 - overflow enable gates overflow flags onto request
// R3 - overflow while high sets high flag
// R4 - overflow while low sets low flag
// R5 - write 0 clears flag, 1 ignored
// R6 - code 01: rising edges, low register, request
// R7 - code 10: falling edges, high register, request
// R8 - code 11: both edges, both registers
// R9 - code 00: no detection, no request
// R10 - edge selection itself enables edge request
// R11 - edge flag set on selected edge
// R12 - software writes zero to reserved bit
// R13 - reserved bit always reads zero
// R14 - unused bits ignore writes, read zero
// R15 - clock bits 3:2 choose count clock
// R16 - clock bits 1:0 choose filter clock
// R17 - high register captures on falling edge
// R18 - low register captures on rising edge
// R19 - counter clears after latching on edge
// R20 - filter integrates levels zero to six
// R21 - periods 2..16 count, 1..8 filter
// R22 - select codes ascend to longer periods
// R23 - edge and overflow share one request
module pwm_timer import pwm_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic inst_en_i,
    input wire logic pulse_input_pin_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic shared_irq_line_o
);
    typedef struct packed {
        logic overflow_irq_enable;
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic [1:0] edge_select;
        logic edge_detect_flag;
        logic [1:0] count_clock_sel;
        logic [1:0] filter_clock_sel;
        pwm_byte_t high_width_result;
        pwm_byte_t low_width_result;
        pwm_byte_t counter;
        logic level_prev;
        pwm_byte_t rdata;
    } pwm_state_t;

    pwm_state_t s_q;
    pwm_state_t s_d;

    logic cnt_tick;
    logic flt_tick;
    logic filtered_pulse;
    logic rise;
    logic fall;
    logic rise_sel;
    logic fall_sel;
    logic overflow;
    logic wr_ctrl;
    logic wr_clk;

    pwm_prescaler #(
        .WIDTH(PRESC_W)
    ) u_presc (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .inst_en_i(inst_en_i),
        .cnt_sel_i(s_q.count_clock_sel),
        .flt_sel_i(s_q.filter_clock_sel),
        .cnt_tick_o(cnt_tick),
        .flt_tick_o(flt_tick)
    );

    pwm_filter u_filter (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .sample_en_i(flt_tick),
        .pulse_i(pulse_input_pin_i),
        .level_o(filtered_pulse)
    );

    // read mux shared by the data register and nothing else
    function automatic pwm_byte_t read_value(input pwm_state_t s, input logic lvl,
                                             input logic [ADDR_W-1:0] a);
        pwm_byte_t v;
        v = '0;
        case (a)
            OFS_CTRL_STATUS: begin
                v[BIT_FILT_LEVEL] = lvl; // [R1]
                v[BIT_OVF_IRQ_EN] = s.overflow_irq_enable;
                v[BIT_HIGH_OVF] = s.high_overflow_flag;
                v[BIT_LOW_OVF] = s.low_overflow_flag;
                v[BIT_EDGE_HI] = s.edge_select[1];
                v[BIT_EDGE_LO] = s.edge_select[0];
                v[BIT_EDGE_FLAG] = s.edge_detect_flag;
            end
            OFS_CLOCK_SEL: begin
                // bit 7 and unused bits 6:4 read as zero
                v[BIT_CNT_SEL_HI] = s.count_clock_sel[1]; // [R13] [R14]
                v[BIT_CNT_SEL_LO] = s.count_clock_sel[0];
                v[BIT_FLT_SEL_HI] = s.filter_clock_sel[1];
                v[BIT_FLT_SEL_LO] = s.filter_clock_sel[0];
            end
            OFS_HIGH_RESULT: begin
                v = s.high_width_result;
            end
            OFS_LOW_RESULT: begin
                v = s.low_width_result;
            end
            default: begin
                v = '0;
            end
        endcase
        return v;
    endfunction

    assign rise = filtered_pulse && !s_q.level_prev;
    assign fall = !filtered_pulse && s_q.level_prev;
    // edge select code both chooses the edge and enables its request
    assign rise_sel = rise && s_q.edge_select[0]; // [R6] [R8] [R9] [R10]
    assign fall_sel = fall && s_q.edge_select[1]; // [R7] [R8] [R9] [R10]
    assign overflow = cnt_tick && (s_q.counter == CNT_MAX);
    assign wr_ctrl = wr_i && (addr_i == OFS_CTRL_STATUS);
    assign wr_clk = wr_i && (addr_i == OFS_CLOCK_SEL);

    always_comb begin
        s_d = s_q;
        s_d.level_prev = filtered_pulse;

        // software writes first, so hardware events below win over a clear
        if (wr_ctrl) begin
            s_d.overflow_irq_enable = wdata_i[BIT_OVF_IRQ_EN];
            s_d.edge_select = {wdata_i[BIT_EDGE_HI], wdata_i[BIT_EDGE_LO]};
            s_d.high_overflow_flag = s_q.high_overflow_flag & wdata_i[BIT_HIGH_OVF]; // [R5]
            s_d.low_overflow_flag = s_q.low_overflow_flag & wdata_i[BIT_LOW_OVF]; // [R5]
            s_d.edge_detect_flag = s_q.edge_detect_flag & wdata_i[BIT_EDGE_FLAG]; // [R5]
        end
        if (wr_clk) begin
            // reserved and unused bits are dropped on write
            s_d.count_clock_sel = {wdata_i[BIT_CNT_SEL_HI], wdata_i[BIT_CNT_SEL_LO]}; // [R14] [R15]
            s_d.filter_clock_sel = {wdata_i[BIT_FLT_SEL_HI], wdata_i[BIT_FLT_SEL_LO]}; // [R16]
        end

        // counter runs on the count enable and wraps at overflow
        if (cnt_tick) begin
            s_d.counter = s_q.counter + 8'h01;
        end
        if (overflow && filtered_pulse) begin
            s_d.high_overflow_flag = 1'b1; // [R3]
        end
        if (overflow && !filtered_pulse) begin
            s_d.low_overflow_flag = 1'b1; // [R4]
        end

        if (fall) begin
            s_d.high_width_result = s_q.counter; // [R17]
        end
        if (rise) begin
            s_d.low_width_result = s_q.counter; // [R18]
        end
        if (rise_sel || fall_sel) begin
            s_d.counter = CNT_ZERO; // [R19]
            s_d.edge_detect_flag = 1'b1; // [R11]
        end

        if (rd_i) begin
            s_d.rdata = read_value(s_q, filtered_pulse, addr_i);
        end else begin
            s_d.rdata = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q.overflow_irq_enable <= 1'b0;
            s_q.high_overflow_flag <= 1'b0;
            s_q.low_overflow_flag <= 1'b0;
            s_q.edge_select <= RST_SEL;
            s_q.edge_detect_flag <= 1'b0;
            s_q.count_clock_sel <= RST_SEL;
            s_q.filter_clock_sel <= RST_SEL;
            s_q.high_width_result <= RST_RESULT;
            s_q.low_width_result <= RST_RESULT;
            s_q.counter <= CNT_ZERO;
            s_q.level_prev <= 1'b0;
            s_q.rdata <= RST_RESULT;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    // edge flag only requests while an edge is selected
    assign shared_irq_line_o = (s_q.edge_detect_flag && (s_q.edge_select != EDGE_NONE)) // [R9] [R10] [R23]
        || (s_q.overflow_irq_enable && (s_q.high_overflow_flag || s_q.low_overflow_flag)); // [R2] [R23]
endmodule // pwm_timer

/* pwm_timer_monitor.sv */
// checker on the pulse width timer ports
`timescale 1ns/1ps
module pwm_timer_monitor import pwm_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic inst_en_i,
    input wire logic pulse_input_pin_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic shared_irq_line_o
);
    typedef struct packed {
        logic [1:0] sel;
        logic oen;
        logic [3:0] csel;
        logic pin;
        logic [3:0] run;
    } pwm_mon_t;
    pwm_mon_t s_q, s_d;
    logic rd_st;
    assign rd_st = rd_i && addr_i == OFS_CTRL_STATUS;
    // run restarts on a pin change or clock reselect, so a run of 12 or more at filter clock select 00 means the filter has settled
    always_comb begin
        s_d = s_q;
        s_d.pin = pulse_input_pin_i;
        if (pulse_input_pin_i != s_q.pin || (wr_i && addr_i == OFS_CLOCK_SEL)) s_d.run = 4'h0;
        else if (inst_en_i && s_q.run != 4'hf) s_d.run = s_q.run + 4'h1;
        if (wr_i && addr_i == OFS_CLOCK_SEL) s_d.csel = wdata_i[3:0];
        if (wr_i && addr_i == OFS_CTRL_STATUS) begin
            s_d.sel = wdata_i[BIT_EDGE_HI:BIT_EDGE_LO];
            s_d.oen = wdata_i[BIT_OVF_IRQ_EN];
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) s_q <= '0;
        else s_q <= s_d;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
    unmapped_zero_a: assert property (rd_i && (addr_i < OFS_CTRL_STATUS || addr_i > OFS_LOW_RESULT)
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    status_top_a: assert property (rd_st |=> !rdata_o[7]) else $error("status bit 7 set");
    clksel_read_a: assert property (rd_i && addr_i == OFS_CLOCK_SEL
        |=> rdata_o == {4'h0, $past(s_q.csel)}) else $error("clock select readback wrong");
    ctrl_read_a: assert property (rd_st |=> rdata_o[5] == $past(s_q.oen)
        && rdata_o[2:1] == $past(s_q.sel)) else $error("control readback wrong");
    irq_source_a: assert property (rd_st |=> ((rdata_o[0] && $past(s_q.sel) != 2'h0)
        || (rdata_o[4:3] != 2'h0 && $past(s_q.oen))) == $past(shared_irq_line_o)) else $error("request mismatch");
    irq_quiet_a: assert property (s_q.sel == 2'h0 && !s_q.oen |-> !shared_irq_line_o)
        else $error("request while disabled");
    level_read_a: assert property (rd_st && s_q.run >= 4'hc && s_q.csel[1:0] == 2'h0
        |=> rdata_o[6] == $past(pulse_input_pin_i)) else $error("level bit wrong");
endmodule // pwm_timer_monitor
bind pwm_timer pwm_timer_monitor mon_u (.clk_i(clk_i), .rstn_i(rstn_i), .inst_en_i(inst_en_i),
    .pulse_input_pin_i(pulse_input_pin_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .shared_irq_line_o(shared_irq_line_o));

/* pwm_pulse_src.sv */
// pulse source model driving the measurement pin
`timescale 1ns/1ps
module pwm_pulse_src (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic idle_i,
    input wire logic [7:0] hi_len_i,
    input wire logic [7:0] lo_len_i,
    output logic pulse_o = 1'b0
);
    logic [7:0] cnt_q = 8'h01;
    always @(posedge clk_i) begin
        if (!en_i || cnt_q >= (pulse_o ? hi_len_i : lo_len_i)) cnt_q <= 8'h01;
        else cnt_q <= cnt_q + 8'h01;
        if (!en_i) pulse_o <= idle_i;
        else if (cnt_q >= (pulse_o ? hi_len_i : lo_len_i)) pulse_o <= ~pulse_o;
    end
endmodule // pwm_pulse_src

/* testbench.sv */
// testbench: register map, edge modes, filter, overflow and reset
`timescale 1ns/1ps
module testbench import pwm_pkg::*; ;
    logic clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, en = 1'b0, idle = 1'b0, pin, irq;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, rd_v;
    int failures = 0, n_checks = 0, cyc = 0;
    logic [24:0] rows [10] = '{{1'b0, 8'h34, 8'h00, 8'h00}, {1'b0, 8'h35, 8'h00, 8'h00},
        {1'b0, 8'h36, 8'h00, 8'h00}, {1'b0, 8'h37, 8'h00, 8'h00}, {1'b0, 8'h3a, 8'h00, 8'h00},
        {1'b1, 8'h35, 8'h70, 8'h00}, {1'b1, 8'h35, 8'h0f, 8'h0f}, {1'b1, 8'h36, 8'h5a, 8'h00},
        {1'b1, 8'h34, 8'hc6, 8'h06}, {1'b1, 8'h34, 8'h20, 8'h20}};
    pwm_timer dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .inst_en_i(1'b1), .pulse_input_pin_i(pin), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .shared_irq_line_o(irq));
    pwm_pulse_src src_u (.clk_i(clk_i), .en_i(en), .idle_i(idle), .hi_len_i(8'h18), .lo_len_i(8'h28),
        .pulse_o(pin));
    initial forever #20 clk_i = ~clk_i;
    task automatic print_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            failures++;
            print_verdict;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // a capture may miss the tick that lands on the clearing edge
    task automatic near(input logic [7:0] v, input int e);
        check((v == e[7:0] || v == e[7:0] - 8'h01) ? e[7:0] : v, e[7:0]);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        // taken at the next edge, before the registers move again
        @(posedge clk_i);
        rd_v = rdata_o;
    endtask
    task automatic wait_irq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++) begin
            @(posedge clk_i);
        end
        check({7'h0, irq}, 8'h01);
    endtask
    task automatic measure(input logic [1:0] code, input logic [3:0] csel, input logic flag, input int eh, input int el);
        wr(8'h35, {4'h0, csel});
        wr(8'h34, {5'h00, code, 1'b0});
        en <= 1'b1;
        repeat (200) @(posedge clk_i);
        wr(8'h34, {5'h00, code, 1'b0});
        repeat (192) @(posedge clk_i);
        rd(8'h34);
        check({7'h0, rd_v[0]}, {7'h0, flag});
        check({7'h0, irq}, {7'h0, flag});
        rd(8'h36);
        if (eh >= 0) near(rd_v, eh);
        rd(8'h37);
        if (el >= 0) near(rd_v, el);
        en <= 1'b0;
        $display("test edge mode %0d done", code);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            check(rd_v, rows[i][7:0]);
        end
        $display("test register table done");
        measure(2'h1, 4'h0, 1'b1, -1, 32);
        measure(2'h2, 4'hd, 1'b1, 4, -1);
        measure(2'h3, 4'h8, 1'b1, 3, 5);
        measure(2'h0, 4'h6, 1'b0, -1, -1);
        measure(2'h3, 4'h3, 1'b0, -1, -1);
        wr(8'h35, 8'h00);
        wr(8'h34, 8'h20);
        wait_irq(600);
        rd(8'h34);
        check(rd_v, 8'h28);
        wr(8'h34, 8'h39);
        rd(8'h34);
        check(rd_v, 8'h28);
        wr(8'h34, 8'h20);
        @(posedge clk_i);
        check({7'h0, irq}, 8'h00);
        idle <= 1'b1;
        repeat (4) @(posedge clk_i);
        idle <= 1'b0;
        repeat (10) @(posedge clk_i);
        rd(8'h34);
        check(rd_v & 8'h40, 8'h00);
        idle <= 1'b1;
        repeat (20) @(posedge clk_i);
        wr(8'h34, 8'h20);
        wait_irq(600);
        rd(8'h34);
        check(rd_v, 8'h70);
        $display("test overflow and filter done");
        idle <= 1'b0;
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(8'h34);
        check(rd_v, 8'h00);
        $display("test second reset done");
        print_verdict;
    end
endmodule // testbench
